// ==== dv/iapfc_ctrl_assertions.sv ====
// port assertions for the flash erase/write control block
`timescale 1ns/100ps
`default_nettype none
`include "iapfc_consts.vh"
module iapfc_chk
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        reg_wr,
  input wire logic [3:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        cpu_halt,
  input wire logic        chip_reset,
  input wire logic        flash_erase,
  input wire logic        flash_program,
  input wire logic        flash_read,
  input wire logic [13:0] flash_addr,
  input wire logic [8:0]  tag_page,
  input wire logic [31:0] tag_mask
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire       cmd_wr = reg_wr && reg_addr == `IAPFC_REG_CMD;   // command
  wire       hi_wr = reg_wr && reg_addr == `IAPFC_REG_D0_HI; // word load
  wire [2:0] op = reg_wdata[6:4];                           // op written
  // a read start halts the cpu, then releases it; erase/program keep it halted at least 8 cycles
  sequence s_read_run;
    ##[0:1] cpu_halt ##[1:8] !cpu_halt;
  endsequence
  sequence s_long_run;
    ##[0:1] cpu_halt [*8];
  endsequence
  property p_reset_key;
    chip_reset == $past(reg_wr && reg_addr == `IAPFC_REG_RSTKEY &&
                        reg_wdata == `IAPFC_RESET_KEY);
  endproperty
  a_reset_key: assert property (p_reset_key)
    else $error("chip reset not tied to key write");
  property p_read_go;
    flash_read |-> $past(cmd_wr && op == `IAPFC_OP_READ &&
                         reg_wdata[1:0] == 2'b11);
  endproperty
  a_read_go: assert property (p_read_go)
    else $error("read started without permit");
  property p_erase_go;
    flash_erase |-> $past(cmd_wr && op == `IAPFC_OP_ERASE && reg_wdata[2]);
  endproperty
  a_erase_go: assert property (p_erase_go)
    else $error("erase start without erase code");
  property p_prog_go;
    flash_program |-> $past(cmd_wr && op == `IAPFC_OP_PROGRAM &&
                            reg_wdata[2]);
  endproperty
  a_prog_go: assert property (p_prog_go)
    else $error("program start without program code");
  property p_read_run;
    flash_read |-> s_read_run;
  endproperty
  a_read_run: assert property (p_read_run)
    else $error("read halt wrong");
  property p_long_run;
    flash_erase || flash_program |-> s_long_run;
  endproperty
  a_long_run: assert property (p_long_run)
    else $error("cpu not halted during erase or program");
  property p_addr_inc;
    hi_wr && flash_addr[4:0] != 5'h1F |=>
      flash_addr == $past(flash_addr) + 14'h0001;
  endproperty
  a_addr_inc: assert property (p_addr_inc)
    else $error("address not incremented after word load");
  property p_addr_hold;
    hi_wr && flash_addr[4:0] == 5'h1F |=> $stable(flash_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address passed page end");
  property p_tag;
    hi_wr |=> tag_mask[$past(flash_addr[4:0])] &&
              tag_page == $past(flash_addr[13:5]);
  endproperty
  a_tag: assert property (p_tag)
    else $error("word load not tagged");
endmodule // iapfc_chk
bind iapfc_ctrl iapfc_chk u_chk
(
  .clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .cpu_halt(cpu_halt), .chip_reset(chip_reset),
  .flash_erase(flash_erase), .flash_program(flash_program),
  .flash_read(flash_read), .flash_addr(flash_addr), .tag_page(tag_page),
  .tag_mask(tag_mask)
);
`default_nettype wire

// ==== dv/iapfc_ctrl_bench.sv ====
// self-checking bench for the flash erase/write control block
`timescale 1ns/100ps
`default_nettype none
`include "iapfc_consts.vh"
module iapfc_ctrl_bench;
  logic        clk = 1'b0;      // 50 MHz
  logic        sys_rst = 1'b1;  // sync reset
  logic        reg_wr = 1'b0;   // write strobe
  logic [3:0]  reg_addr = 4'h0; // register index
  logic [7:0]  reg_wdata = 8'h00;
  logic        rd_req = 1'b0;   // read address presented
  logic        rd_d = 1'b0;     // read data due
  wire  [7:0]  reg_rdata;
  wire         cpu_halt, chip_reset, flash_erase, flash_program, flash_read;
  wire  [13:0] flash_addr;
  wire  [8:0]  tag_page;
  wire  [31:0] tag_mask;
  wire  [15:0] flash_rdata, buf_word;
  logic [31:0] n = 32'h0;       // start pulses, one count per byte
  logic [7:0]  exp_q[$];        // expected read bytes
  logic [31:0] r;               // random draw
  int          mismatches = 0, compares = 0, cyc = 0;
  always #10 clk = ~clk;
  iapfc_ctrl #(.UNLOCK_CYC(18'h00010)) u_dut
  (
    .clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cpu_halt(cpu_halt),
    .chip_reset(chip_reset), .flash_erase(flash_erase),
    .flash_program(flash_program), .flash_read(flash_read),
    .flash_addr(flash_addr), .tag_page(tag_page), .tag_mask(tag_mask),
    .flash_rdata(flash_rdata), .buf_word(buf_word)
  );
  iapfc_flash_model u_flash
  (
    .clk(clk), .flash_read(flash_read), .flash_addr(flash_addr),
    .flash_rdata(flash_rdata)
  );
  task automatic stop_test;
    if (mismatches == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  // one write, taken at the second edge; #1 lets its updates land
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    rd_req <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd_req <= 1'b0;
    #1;
  endtask
  // key writes must fit in the shortened window
  task automatic unlock(input logic [7:0] last, input logic [7:0] e);
    wr(`IAPFC_REG_CMD, 8'h68);
    rd(`IAPFC_REG_CMD, 8'h68);
    wr(`IAPFC_REG_D1_LO, `IAPFC_KEY1_LO);
    wr(`IAPFC_REG_D1_HI, `IAPFC_KEY1_HI);
    wr(`IAPFC_REG_D2_LO, `IAPFC_KEY2_LO);
    wr(`IAPFC_REG_D2_HI, `IAPFC_KEY2_HI);
    wr(`IAPFC_REG_D3_LO, `IAPFC_KEY3_LO);
    wr(`IAPFC_REG_D3_HI, last);
    repeat (24) @(posedge clk);
    rd(`IAPFC_REG_CMD, e);
  endtask
  task automatic abort;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`IAPFC_REG_CMD, `IAPFC_RST_BYTE);    // reset value
  endtask
  // read compare, start pulse counts and hang guard
  always @(posedge clk)
  begin
    rd_d <= rd_req;
    if (rd_d)
      chk("reg_rdata", exp_q.pop_front(), reg_rdata);
    if (!sys_rst)
      n <= n + {7'h0, chip_reset, 7'h0, flash_read, 7'h0, flash_erase,
                7'h0, flash_program};
    if (++cyc == 4000)
    begin
      mismatches++;
      stop_test;
    end
  end
  initial
  begin
    r = $urandom(32'he0d5);
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`IAPFC_REG_RSTKEY, `IAPFC_RST_BYTE);
    rd(`IAPFC_REG_TIMBUF, `IAPFC_RST_BYTE);
    wr(`IAPFC_REG_CMD, 8'h80);
    rd(`IAPFC_REG_CMD, 8'h00);
    r = $urandom;
    wr(`IAPFC_REG_ADDR_HI, {2'h0, r[5:0]});
    wr(`IAPFC_REG_ADDR_LO, 8'h1E);
    wr(`IAPFC_REG_D0_LO, r[15:8]);
    wr(`IAPFC_REG_D0_HI, r[23:16]);
    chk("flash_addr", {r[5:0], 8'h1F}, flash_addr);
    wr(`IAPFC_REG_D0_LO, r[31:24]);
    wr(`IAPFC_REG_D0_HI, r[7:0]);
    chk("flash_addr", {r[5:0], 8'h1F}, flash_addr);
    chk("buf_word", {r[7:0], r[31:24]}, buf_word);
    chk("tag_mask", 32'hC0000000, tag_mask);
    chk("tag_page", {r[5:0], 3'h0}, tag_page);
    wr(`IAPFC_REG_TIMBUF, 8'h03);
    repeat (36) @(posedge clk);
    rd(`IAPFC_REG_TIMBUF, 8'h02);
    chk("buf_word", 32'h0, buf_word);
    wr(`IAPFC_REG_RSTKEY, 8'h54);
    wr(`IAPFC_REG_RSTKEY, `IAPFC_RESET_KEY);
    rd(`IAPFC_REG_RSTKEY, `IAPFC_RESET_KEY);
    chk("starts", 32'h01000000, n);
    wr(`IAPFC_REG_CMD, 8'h31);
    r = $urandom;
    wr(`IAPFC_REG_ADDR_LO, r[7:0]);
    wr(`IAPFC_REG_ADDR_HI, {2'h0, r[13:8]});
    chk("starts", 32'h01000000, n);
    wr(`IAPFC_REG_CMD, 8'h33);
    chk("cpu_halt", 32'h1, cpu_halt);
    repeat (8) @(posedge clk);
    rd(`IAPFC_REG_CMD, 8'h32);
    rd(`IAPFC_REG_D0_LO, r[7:0] ^ 8'hC3);
    rd(`IAPFC_REG_D0_HI, {2'h0, r[13:8]} ^ 8'hA5);
    unlock(r[7:0] | 8'h80, 8'h60);
    unlock(`IAPFC_KEY3_HI, 8'hE0);
    wr(`IAPFC_REG_CMD, 8'h60);
    rd(`IAPFC_REG_CMD, 8'h60);
    wr(`IAPFC_REG_CMD, 8'h04);
    unlock(`IAPFC_KEY3_HI, 8'hE0);
    for (int i = 2; i < 8; i++)
      if (i != 3 && i != 6)
        wr(`IAPFC_REG_CMD, {1'b1, i[2:0], 4'h4});
    chk("starts", 32'h01010000, n);
    wr(`IAPFC_REG_CMD, 8'h94);
    chk("cpu_halt", 32'h1, cpu_halt);
    repeat (50) @(posedge clk);
    rd(`IAPFC_REG_CMD, 8'h94);
    chk("starts", 32'h01010100, n);
    abort;
    unlock(`IAPFC_KEY3_HI, 8'hE0);
    wr(`IAPFC_REG_CMD, 8'h84);
    repeat (50) @(posedge clk);
    rd(`IAPFC_REG_CMD, 8'h84);
    chk("starts", 32'h01010101, n);
    abort;
    // let the last queued read reach its compare
    repeat (2) @(posedge clk);
    stop_test;
  end
endmodule // iapfc_ctrl_bench
`default_nettype wire

// ==== dv/iapfc_flash_model.sv ====
// behavioural flash array answering read starts
`timescale 1ns/100ps
`default_nettype none
module iapfc_flash_model
(
  input  wire logic        clk,
  input  wire logic        flash_read,
  input  wire logic [13:0] flash_addr,
  output var  logic [15:0] flash_rdata
);
  logic [15:0] hold = 16'h0000; // word on the data lines
  logic [2:0]  left = 3'h0;     // cycles the word stays valid
  // word valid for eight cycles from a start, then the lines toggle
  // every cycle so a stale capture cannot pass for data
  always @(posedge clk)
  begin
    if (flash_read)
    begin
      hold <= {2'h0, flash_addr} ^ 16'hA5C3;
      left <= 3'h7;
    end
    else if (left != 3'h0)
      left <= left - 3'h1;
    else
      hold <= ~hold;
  end
  assign flash_rdata = hold;
endmodule // iapfc_flash_model
`default_nettype wire

// ==== rtl/iapfc_consts.vh ====
// constants for the flash erase/write control block
`ifndef IAPFC_CONSTS_VH
`define IAPFC_CONSTS_VH

// register indices on the special function register port
`define IAPFC_REG_CMD        4'h0
`define IAPFC_REG_RSTKEY     4'h1
`define IAPFC_REG_TIMBUF     4'h2
`define IAPFC_REG_ADDR_LO    4'h3
`define IAPFC_REG_ADDR_HI    4'h4
`define IAPFC_REG_D0_LO      4'h5
`define IAPFC_REG_D0_HI      4'h6
`define IAPFC_REG_D1_LO      4'h7
`define IAPFC_REG_D1_HI      4'h8
`define IAPFC_REG_D2_LO      4'h9
`define IAPFC_REG_D2_HI      4'hA
`define IAPFC_REG_D3_LO      4'hB
`define IAPFC_REG_D3_HI      4'hC

// command/control bit positions
`define IAPFC_BIT_MODEN      7
`define IAPFC_BIT_OPSEL_HI   6
`define IAPFC_BIT_OPSEL_LO   4
`define IAPFC_BIT_UNLOCK     3
`define IAPFC_BIT_PGO        2
`define IAPFC_BIT_RPERMIT    1
`define IAPFC_BIT_RGO        0
`define IAPFC_BIT_DURSEL     1
`define IAPFC_BIT_BCLR       0

// operation select codes
`define IAPFC_OP_PROGRAM     3'h0
`define IAPFC_OP_ERASE       3'h1
`define IAPFC_OP_READ        3'h3
`define IAPFC_OP_UNLOCK      3'h6

// key bytes, low halves then high halves of pairs one to three
`define IAPFC_KEY1_LO        8'h00
`define IAPFC_KEY2_LO        8'h0D
`define IAPFC_KEY3_LO        8'hC3
`define IAPFC_KEY1_HI        8'h04
`define IAPFC_KEY2_HI        8'h09
`define IAPFC_KEY3_HI        8'h40
`define IAPFC_RESET_KEY      8'h55

// reset values
`define IAPFC_RST_BYTE       8'h00

// timing counts in 50 MHz clock cycles, sized for the 18-bit timer;
// erase 3.2 ms / 3.7 ms, program 2.2 ms / 3.0 ms
// a different system clock needs these counts worked out again
`define IAPFC_T_ERASE0_CYC   18'h27100
`define IAPFC_T_ERASE1_CYC   18'h2D2A8
`define IAPFC_T_PROG0_CYC    18'h1ADB0
`define IAPFC_T_PROG1_CYC    18'h249F0
`define IAPFC_T_UNLOCK_CYC   18'h00400
`define IAPFC_T_READ_CYC     18'h00004
`define IAPFC_T_BCLR_CYC     18'h00020

`endif

// ==== rtl/iapfc_ctrl.v ====
// flash erase/write/read sequencer with its register set
// Summary of operation
// - op codes: program, erase, read, unlock
// - unlock trigger starts timer, cleared at expiry
// - correct key sets modify-enabled flag
// - wrong key leaves erase/program disabled
// - trigger clears at expiry regardless of key
// - mode and trigger accepted in one write
// - clearing enabled flag disables from the next write; same-write go still runs
// - program-go runs operation, hardware clears it
// - read-go runs read, hardware clears it
// - reads only while read-permit set
// - cpu halted while operation runs
// - writing 55h to reset key resets chip
// - erase time 3.2ms or 3.7ms
// - program time 2.2ms or 3.0ms
// - buffer-clear bit clears buffer, self-clears
// - first high data write tags address, increments
// - word offset stops at 11111b
// - first high write loads 16-bit word
// - writing one to enabled flag ignored
// - buffer holds one 32-word page
`timescale 1ns/100ps
`default_nettype none
`include "iapfc_consts.vh"
module iapfc_ctrl #(
  parameter [17:0] UNLOCK_CYC = `IAPFC_T_UNLOCK_CYC  // unlock window
)
(
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        reg_wr,       // register write strobe
  input  wire [3:0]  reg_addr,     // register index
  input  wire [7:0]  reg_wdata,    // write data
  output reg  [7:0]  reg_rdata,    // read data, registered
  output wire        cpu_halt,     // stall cpu while busy
  output reg         chip_reset,   // one-cycle whole-chip reset
  output reg         flash_erase,  // one-cycle erase start
  output reg         flash_program,// one-cycle program start
  output reg         flash_read,   // one-cycle read start
  output reg  [13:0] flash_addr,   // address to the array
  output reg  [8:0]  tag_page,     // page of tagged words
  output reg  [31:0] tag_mask,     // tagged word offsets
  input  wire [15:0] flash_rdata,  // array read data
  output wire [15:0] buf_word      // buffer word at offset
);
  localparam [17:0] ERASE0 = `IAPFC_T_ERASE0_CYC;
  localparam [17:0] ERASE1 = `IAPFC_T_ERASE1_CYC;
  localparam [17:0] PROG0  = `IAPFC_T_PROG0_CYC;
  localparam [17:0] PROG1  = `IAPFC_T_PROG1_CYC;
  localparam [17:0] WIN    = UNLOCK_CYC;
  localparam [17:0] RDCYC  = `IAPFC_T_READ_CYC;
  localparam [17:0] BCCYC  = `IAPFC_T_BCLR_CYC;

  // sequencer states
  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_UNLOCK = 3'h1;
  localparam [2:0] ST_OPER   = 3'h2;
  localparam [2:0] ST_READ   = 3'h3;
  localparam [2:0] ST_BCLR   = 3'h4;

  reg  [2:0]  state;              // sequencer state
  reg         mod_en;             // modify-enabled flag
  reg  [2:0]  op_select_field;    // operation select
  reg         unlock_trigger;     // unlock window running
  reg         program_go;         // erase/program busy
  reg         read_permit;        // read gate
  reg         read_go;            // read busy
  reg         duration_select;    // long/short timing
  reg         buffer_clear_go;    // buffer clear busy
  reg  [7:0]  rst_key;            // reset key register
  reg  [7:0]  dlo [0:3];          // data pair low bytes
  reg  [7:0]  dhi [0:3];          // data pair high bytes
  reg  [15:0] wbuf [0:31];        // one-page write buffer
  reg  [17:0] tload;              // timer load value
  reg         tstart;             // timer start strobe
  wire        tbusy;              // timer running
  wire        tdone;              // timer expired

  wire wr_cmd  = reg_wr && reg_addr == `IAPFC_REG_CMD;
  wire wr_tb   = reg_wr && reg_addr == `IAPFC_REG_TIMBUF;
  wire wr_d0hi = reg_wr && reg_addr == `IAPFC_REG_D0_HI;
  wire key_ok  = dlo[1] == `IAPFC_KEY1_LO && dhi[1] == `IAPFC_KEY1_HI
              && dlo[2] == `IAPFC_KEY2_LO && dhi[2] == `IAPFC_KEY2_HI
              && dlo[3] == `IAPFC_KEY3_LO && dhi[3] == `IAPFC_KEY3_HI;
  wire [2:0] wr_op = reg_wdata[`IAPFC_BIT_OPSEL_HI:`IAPFC_BIT_OPSEL_LO];
  wire busy_any = program_go | read_go;

  assign cpu_halt = busy_any;
  assign buf_word = wbuf[flash_addr[4:0]];

  iapfc_timer u_timer
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (tstart),
    .load    (tload),
    .busy    (tbusy),
    .done    (tdone)
  );

  // write buffer storage, cleared by the buffer-clear run
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1)
    begin : g_wbuf
      always @(posedge clk)
      begin
        if (sys_rst || (state == ST_BCLR && tdone))
          wbuf[gi] <= 16'h0000;
        else if (state == ST_OPER && tdone && !op_select_field[0])
          wbuf[gi] <= 16'h0000; // emptied after a program run
        else if (wr_d0hi && flash_addr[4:0] == gi)
          wbuf[gi] <= {reg_wdata, dlo[0]};
      end
    end
  endgenerate

  // data pair registers
  genvar gd;
  generate
    for (gd = 0; gd < 4; gd = gd + 1)
    begin : g_data
      always @(posedge clk)
      begin
        if (sys_rst)
        begin
          dlo[gd] <= `IAPFC_RST_BYTE;
          dhi[gd] <= `IAPFC_RST_BYTE;
        end
        else if (state == ST_READ && tdone && gd == 0)
        begin
          dlo[gd] <= flash_rdata[7:0];
          dhi[gd] <= flash_rdata[15:8];
        end
        else if (reg_wr && reg_addr == `IAPFC_REG_D0_LO + 2 * gd)
          dlo[gd] <= reg_wdata;
        else if (reg_wr && reg_addr == `IAPFC_REG_D0_HI + 2 * gd)
          dhi[gd] <= reg_wdata;
      end
    end
  endgenerate

  // address pair with tag and clamp at the page end
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      flash_addr <= 14'h0000;
      tag_mask   <= 32'h00000000;
      tag_page   <= 9'h000;
    end
    else if (reg_wr && reg_addr == `IAPFC_REG_ADDR_LO)
      flash_addr[7:0] <= reg_wdata;
    else if (reg_wr && reg_addr == `IAPFC_REG_ADDR_HI)
      flash_addr[13:8] <= reg_wdata[5:0];
    else if (wr_d0hi)
    begin
      tag_page <= flash_addr[13:5];
      tag_mask[flash_addr[4:0]] <= 1'b1;
      if (flash_addr[4:0] != 5'h1F)
        flash_addr <= flash_addr + 14'h0001;
    end
    else if (state == ST_OPER && tdone)
      tag_mask <= 32'h00000000; // tags consumed by the run
  end

  // sequencer, command bits and timer control
  always @(posedge clk)
  begin
    tstart        <= 1'b0;
    flash_erase   <= 1'b0;
    flash_program <= 1'b0;
    flash_read    <= 1'b0;
    chip_reset    <= 1'b0;
    if (sys_rst)
    begin
      state           <= ST_IDLE;
      mod_en          <= 1'b0;
      op_select_field <= `IAPFC_OP_PROGRAM;
      unlock_trigger  <= 1'b0;
      program_go      <= 1'b0;
      read_permit     <= 1'b0;
      read_go         <= 1'b0;
      duration_select <= 1'b0;
      buffer_clear_go <= 1'b0;
      rst_key         <= `IAPFC_RST_BYTE;
      tload           <= 18'h00000;
    end
    else
    begin
      if (reg_wr && reg_addr == `IAPFC_REG_RSTKEY)
      begin
        rst_key    <= reg_wdata;
        chip_reset <= reg_wdata == `IAPFC_RESET_KEY;
      end
      if (wr_tb)
        duration_select <= reg_wdata[`IAPFC_BIT_DURSEL];
      if (wr_cmd)
      begin
        // mode and control fields land together
        op_select_field <= wr_op;
        read_permit     <= reg_wdata[`IAPFC_BIT_RPERMIT];
        if (!reg_wdata[`IAPFC_BIT_MODEN])
          mod_en <= 1'b0;
      end
      case (state)
        ST_IDLE:
        begin
          // only the unlock mode opens a window; trigger
          // and mode may arrive in the same write
          if (wr_cmd && reg_wdata[`IAPFC_BIT_UNLOCK]
              && wr_op == `IAPFC_OP_UNLOCK)
          begin
            unlock_trigger <= 1'b1;
            tload  <= WIN;
            tstart <= 1'b1;
            state  <= ST_UNLOCK;
          end
          else if (wr_cmd && reg_wdata[`IAPFC_BIT_PGO] && mod_en
                   && (wr_op == `IAPFC_OP_ERASE
                       || wr_op == `IAPFC_OP_PROGRAM))
          begin
            program_go <= 1'b1;
            flash_erase   <= wr_op == `IAPFC_OP_ERASE;
            flash_program <= wr_op == `IAPFC_OP_PROGRAM;
            if (wr_op == `IAPFC_OP_ERASE)
              tload <= duration_select ? ERASE1 : ERASE0;
            else
              tload <= duration_select ? PROG1 : PROG0;
            tstart <= 1'b1;
            state  <= ST_OPER;
          end
          else if (wr_cmd && reg_wdata[`IAPFC_BIT_RGO]
                   && reg_wdata[`IAPFC_BIT_RPERMIT]
                   && wr_op == `IAPFC_OP_READ)
          begin
            read_go    <= 1'b1;
            flash_read <= 1'b1;
            tload  <= RDCYC;
            tstart <= 1'b1;
            state  <= ST_READ;
          end
          else if (wr_tb && reg_wdata[`IAPFC_BIT_BCLR])
          begin
            buffer_clear_go <= 1'b1;
            tload  <= BCCYC;
            tstart <= 1'b1;
            state  <= ST_BCLR;
          end
        end
        ST_UNLOCK:
          if (tdone)
          begin
            // trigger drops at expiry whatever the key held
            unlock_trigger <= 1'b0;
            if (key_ok)
              mod_en <= 1'b1;
            // a wrong key leaves the flag low for a retry
            state <= ST_IDLE;
          end
        ST_OPER:
          if (tdone)
          begin
            program_go <= 1'b0;
            state      <= ST_IDLE;
          end
        ST_READ:
          if (tdone)
          begin
            read_go <= 1'b0;
            state   <= ST_IDLE;
          end
        ST_BCLR:
          if (tdone)
          begin
            buffer_clear_go <= 1'b0;
            state           <= ST_IDLE;
          end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // registered read-back; unused bits read zero
  always @(posedge clk)
  begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else
      case (reg_addr)
        `IAPFC_REG_CMD:     reg_rdata <= {mod_en, op_select_field,
                              unlock_trigger, program_go,
                              read_permit, read_go};
        `IAPFC_REG_RSTKEY:  reg_rdata <= rst_key;
        `IAPFC_REG_TIMBUF:  reg_rdata <= {6'h00, duration_select,
                              buffer_clear_go};
        `IAPFC_REG_ADDR_LO: reg_rdata <= flash_addr[7:0];
        `IAPFC_REG_ADDR_HI: reg_rdata <= {2'h0, flash_addr[13:8]};
        `IAPFC_REG_D0_LO:   reg_rdata <= dlo[0];
        `IAPFC_REG_D0_HI:   reg_rdata <= dhi[0];
        `IAPFC_REG_D1_LO:   reg_rdata <= dlo[1];
        `IAPFC_REG_D1_HI:   reg_rdata <= dhi[1];
        `IAPFC_REG_D2_LO:   reg_rdata <= dlo[2];
        `IAPFC_REG_D2_HI:   reg_rdata <= dhi[2];
        `IAPFC_REG_D3_LO:   reg_rdata <= dlo[3];
        `IAPFC_REG_D3_HI:   reg_rdata <= dhi[3];
        default:            reg_rdata <= 8'h00;
      endcase
  end
endmodule // iapfc_ctrl
`default_nettype wire

// ==== rtl/iapfc_timer.v ====
// down-counting operation timer with a one-cycle done pulse
`timescale 1ns/100ps
`default_nettype none
module iapfc_timer
(
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        start,     // load and run
  input  wire [17:0] load,      // cycles to run
  output reg         busy,      // counting
  output reg         done       // one-cycle pulse at expiry
);
  reg [17:0] count;             // remaining cycles

  // count down; a new start restarts the run
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      count <= 18'h00000;
      busy  <= 1'b0;
      done  <= 1'b0;
    end
    else if (start)
    begin
      count <= load;
      busy  <= 1'b1;
      done  <= 1'b0;
    end
    else if (busy && count <= 18'h00001)
    begin
      busy  <= 1'b0;
      done  <= 1'b1;
    end
    else
    begin
      count <= busy ? count - 18'h00001 : count;
      done  <= 1'b0;
    end
  end
endmodule // iapfc_timer
`default_nettype wire
